// *** logic/psi_pkg.sv ***
// package: register map, field positions and reset values of the phy status interrupt logic
package psi_pkg;
  localparam int unsigned REG_ADDR_W = 5;
  localparam int unsigned REG_DATA_W = 16;
  localparam int unsigned NUM_EVT = 4;

  // register offsets on the management port
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h12;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h13;

  // event index: shared by mask bits and latched flags (bit = EVT_BASE + index)
  localparam int unsigned EVT_LINK = 0;
  localparam int unsigned EVT_DUPLEX = 1;
  localparam int unsigned EVT_SPEED = 2;
  localparam int unsigned EVT_AUTONEG = 3;
  localparam int unsigned EVT_BASE = 4;

  // interrupt enable register fields
  localparam int unsigned BIT_FORCE_IRQ_TEST = 0;
  localparam int unsigned BIT_GLOBAL_IRQ_ENABLE = 1;

  // interrupt status register fields
  localparam int unsigned BIT_IRQ_PENDING = 2;

  localparam logic [15:0] IRQ_ENABLE_RESET = 16'h0000;
  localparam logic [15:0] READ_UNMAPPED = 16'h0000;
endpackage

// *** logic/psi_evt_if.sv ***
// interface: latched event flags and gating controls between the event latch, the register file and the pin driver
`timescale 1ns/1ps
interface psi_evt_if;
  logic [3:0] flags;
  logic [3:0] masks;
  logic global_en;
  logic test_force;
  logic clear_on_read;

  modport latch
  (
    output flags,
    input clear_on_read
  );

  modport pin
  (
    input flags,
    input masks,
    input global_en,
    input test_force
  );

  modport regs
  (
    input flags,
    output masks,
    output global_en,
    output test_force,
    output clear_on_read
  );
endinterface

// *** logic/psi_event_latch.sv ***
// event latch: change detection on status levels and sticky flags cleared by a status read
`timescale 1ns/1ps
module psi_event_latch
  import psi_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] level_in,
  psi_evt_if.latch evt
);
  logic [3:0] prev;
  logic [3:0] next_prev;
  logic [3:0] flag;
  logic [3:0] next_flag;
  logic primed;
  logic next_primed;
  wire logic [3:0] hit;

  // ==========================================================
  // event detection, one slice per event
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_evt
      if (i == EVT_AUTONEG)
      begin : g_rise
        // completion is an edge into the done state, not any change
        assign hit[i] = primed & level_in[i] & ~prev[i]; // R8
      end
      else
      begin : g_chg
        assign hit[i] = primed & (level_in[i] ^ prev[i]); // R9 R10 R11
      end
    end
  endgenerate

  // ==========================================================
  // sticky flags
  always_comb
  begin
    next_prev = level_in;
    // first cycle after reset only learns the levels, so reset is no change
    next_primed = 1'b1;
    // a new event in the read cycle survives: set wins over clear
    next_flag = (evt.clear_on_read ? 4'h0 : flag) | hit; // R8 R9 R10 R11
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      prev <= 4'h0;
      primed <= 1'b0;
      flag <= 4'h0;
    end
    else
    begin
      prev <= next_prev;
      primed <= next_primed;
      flag <= next_flag;
    end
  end

  assign evt.flags = flag;
endmodule

// *** logic/psi_irq_pin.sv ***
// interrupt pin driver: masks, global gate and test force onto one active-low output
`timescale 1ns/1ps
module psi_irq_pin
  import psi_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  psi_evt_if.pin evt,
  output logic pending_out,
  output logic irq_n_out
);
  logic pending;
  logic next_pending;
  logic irq_n;
  logic next_irq_n;

  // ==========================================================
  always_comb
  begin
    next_pending = evt.global_en & (|(evt.flags & evt.masks)); // R1 R2 R3 R4 R5 R13
    next_pending = next_pending | evt.test_force; // R6
    next_irq_n = ~next_pending; // R13
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pending <= 1'b0;
      irq_n <= 1'b1;
    end
    else
    begin
      pending <= next_pending;
      irq_n <= next_irq_n;
    end
  end

  assign pending_out = pending;
  assign irq_n_out = irq_n;
endmodule

// *** logic/psi_top.sv ***
// top: interrupt enable and status registers on the management port, event latch and pin driver
`timescale 1ns/1ps
//
// Contract
// R1: the autoneg_done_mask bit lets a completed auto-negotiation raise the interrupt only when 1.
// R2: the speed_change_mask bit lets a speed change raise the interrupt only when 1.
// R3: the duplex_change_mask bit lets a duplex change raise the interrupt only when 1.
// R4: the link_change_mask bit lets a link change raise the interrupt only when 1.
// R5: global_irq_enable gates every interrupt and resets to 0; the code gates only the event interrupts, not force_irq_test.
// R6: force_irq_test at 1 asserts the interrupt pin whatever the events.
// R7: software writes zeros to the reserved enable bits and ignores them on read.
// R8: autoneg_done_flag reads 1 after completion and clears itself when status is read.
// R9: speed_change_flag latches on a speed change and clears when status is read.
// R10: duplex_change_flag latches on a duplex change and clears when status is read.
// R11: link_change_flag latches on a link change, clears when status is read, resets to 0.
// R12: the pending bit of the status register reads 1 while an interrupt is pending.
// R13: the active-low pin asserts while enabled with any masked flag set, releasing on clear.
module psi_top
  import psi_pkg::*;
#(
  parameter int unsigned DATA_W = 16
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [psi_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic link_up_in,
  input wire logic full_duplex_in,
  input wire logic speed_100_in,
  input wire logic autoneg_complete_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic irq_n_out
);
  // ==========================================================
  // elaboration checks
  if (DATA_W != REG_DATA_W)
  begin : g_bad_width
    $error("psi_top: register width must be 16");
  end

  psi_evt_if evt ();

  logic [DATA_W-1:0] enable_reg;
  logic [DATA_W-1:0] next_enable_reg;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic pending;
  logic [3:0] levels;
  logic rd_status;

  // ==========================================================
  // event sources, ordered by event index
  always_comb
  begin
    levels = 4'h0;
    levels[EVT_LINK] = link_up_in;
    levels[EVT_DUPLEX] = full_duplex_in;
    levels[EVT_SPEED] = speed_100_in;
    levels[EVT_AUTONEG] = autoneg_complete_in;
  end

  psi_event_latch u_latch
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .level_in(levels),
    .evt(evt.latch)
  );

  psi_irq_pin u_pin
  (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .evt(evt.pin),
    .pending_out(pending),
    .irq_n_out(irq_n_out)
  );

  // ==========================================================
  // register access
  // reading status clears the flags at the same edge that captures them
  assign rd_status = reg_rd_in & (reg_addr_in == OFS_IRQ_STATUS); // R8 R9 R10 R11
  assign evt.clear_on_read = rd_status;

  assign evt.masks = enable_reg[EVT_BASE +: 4]; // R1 R2 R3 R4
  assign evt.global_en = enable_reg[BIT_GLOBAL_IRQ_ENABLE]; // R5
  assign evt.test_force = enable_reg[BIT_FORCE_IRQ_TEST]; // R6

  always_comb
  begin
    next_enable_reg = enable_reg;
    // reserved bits are stored as written; software keeps them zero
    if (reg_wr_in && reg_addr_in == OFS_IRQ_ENABLE)
    begin
      next_enable_reg = reg_wdata_in;
    end
    next_rvalid = reg_rd_in;
    next_rdata = rdata;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        OFS_IRQ_ENABLE:
        begin
          next_rdata = enable_reg;
        end
        OFS_IRQ_STATUS:
        begin
          next_rdata = '0;
          next_rdata[EVT_BASE +: 4] = evt.flags; // R8 R9 R10 R11
          next_rdata[BIT_IRQ_PENDING] = pending; // R12
        end
        default:
        begin
          next_rdata = READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      enable_reg <= IRQ_ENABLE_RESET; // R5
      rdata <= '0;
      rvalid <= 1'b0;
    end
    else
    begin
      enable_reg <= next_enable_reg;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata_out = rdata;
  assign reg_rvalid_out = rvalid;
endmodule

// *** bench/psi_top_asserts.sv ***
// checker: port assertions of the interrupt logic
`timescale 1ns/1ps
module psi_asserts
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic link_up_in,
  input wire logic full_duplex_in,
  input wire logic speed_100_in,
  input wire logic autoneg_complete_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic irq_n_out
);
  logic [7:0] en_q;
  logic st;
  assign st = reg_rd_in && reg_addr_in == 5'h13;
  // enable shadow, so gating is judged from the ports alone
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      en_q <= 8'h00;
    else if (reg_wr_in && reg_addr_in == 5'h12)
      en_q <= reg_wdata_in[7:0];
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence quiet;
    $stable({link_up_in, full_duplex_in, speed_100_in, autoneg_complete_in});
  endsequence
  chk_en_readback: assert property (reg_rd_in && reg_addr_in == 5'h12 |=>
    reg_rdata_out[7:0] == $past(en_q)) else $error("enable readback");
  chk_pend_mirror: assert property (st |=> reg_rdata_out[2] == !$past(irq_n_out))
    else $error("pending bit");
  chk_force_pin: assert property (reg_wr_in && reg_addr_in == 5'h12 && reg_wdata_in[0]
    |-> ##2 !irq_n_out) else $error("test force");
  chk_gate_off: assert property ((!en_q[1] && !en_q[0]) [*2] |-> irq_n_out)
    else $error("gate off");
  chk_mask_block: assert property (
    (en_q[7:4] == 4'h0 && !en_q[0]) [*2] |-> irq_n_out) else $error("mask off");
  chk_irq_cause: assert property ($fell(irq_n_out) |-> $past(en_q[1]) || $past(en_q[0]))
    else $error("irq cause");
  chk_event_raise: assert property (
    en_q[1] && |(en_q[7:4] & {$rose(autoneg_complete_in), $changed(speed_100_in),
    $changed(full_duplex_in), $changed(link_up_in)}) |-> ##[1:3] !irq_n_out)
    else $error("event irq");
  chk_status_clear: assert property (
    quiet [*2] ##1 st ##0 quiet ##1 quiet [*2] ##1 st ##0 quiet
    |=> reg_rdata_out[7:4] == 4'h0) else $error("read clear");
endmodule

// *** bench/psi_mgmt_model.sv ***
// partner: management controller on the decoded register port
`timescale 1ns/1ps
module psi_mgmt_model
(
  input wire logic clk_in,
  input wire logic [15:0] rdata_in,
  input wire logic rvalid_in,
  output logic [4:0] addr_out = 5'h00,
  output logic wr_out = 1'b0,
  output logic rd_out = 1'b0,
  output logic [15:0] wdata_out = 16'h0000
);
  // released address and data lines carry inverted values so stale data never looks valid
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] v,
    output logic [15:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v & 16'h00f3;
    wr_out <= w;
    rd_out <= !w;
    @(posedge clk_in);
    {wr_out, rd_out} <= 2'b00;
    addr_out <= ~a;
    wdata_out <= ~v;
    // read answer stands for one cycle after the taking edge: sample it mid-cycle
    @(negedge clk_in);
    d = rvalid_in ? rdata_in : 16'hxxxx;
    @(posedge clk_in);
  endtask
endmodule

// *** bench/test_phy_status_interrupt_logic.sv ***
// testbench: register scenarios for the interrupt logic
`timescale 1ns/1ps
module test_phy_status_interrupt_logic;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] lvl = 4'h0;
  logic [4:0] addr;
  logic wr, rd, rv, irq_n;
  logic [15:0] wd, rdat, d;
  logic [7:0] ev [6] = '{8'h12, 8'h22, 8'h42, 8'h82, 8'h02, 8'hf0};
  int err_count = 0;
  int checked = 0;
  psi_top psi_top_i (.clk_in, .rst_n_in, .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wd), .link_up_in(lvl[0]), .full_duplex_in(lvl[1]),
    .speed_100_in(lvl[2]), .autoneg_complete_in(lvl[3]), .reg_rdata_out(rdat),
    .reg_rvalid_out(rv), .irq_n_out(irq_n));
  psi_mgmt_model psi_mgmt_model_i (.clk_in, .rdata_in(rdat), .rvalid_in(rv),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wd));
  task chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    err_count += int'(s !== e);
    if (s !== e)
      $display("ERROR %0t got %h exp %h", $time, s, e);
  endtask
  task rs(input logic [4:0] a, input logic [15:0] e);
    psi_mgmt_model_i.xfer(1'b0, a, 16'h0000, d);
    chk(d, e);
  endtask
  task wm(input logic [15:0] v);
    psi_mgmt_model_i.xfer(1'b1, 5'h12, v, d);
  endtask
  task end_of_test;
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #4 clk_in = ~clk_in;
  initial
  begin
    #20000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rs(5'h12, 16'h0000);
    rs(5'h13, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      wm({8'h00, ev[i]});
      lvl[i % 4] <= ~lvl[i % 4];
      repeat (4) @(posedge clk_in);
      chk({15'h0, irq_n}, {15'h0, i > 3});
      rs(5'h13, 16'h0010 << i % 4 | {13'h0, i < 4, 2'h0});
      rs(5'h13, 16'h0000);
      chk({15'h0, irq_n}, 16'h0001);
    end
    wm(16'h0001);
    @(posedge clk_in);
    chk({15'h0, irq_n}, 16'h0000);
    rs(5'h13, 16'h0004);
    wm(16'h0000);
    // a write to the status offset must leave the enable register alone
    psi_mgmt_model_i.xfer(1'b1, 5'h13, 16'h00f3, d);
    rs(5'h12, 16'h0000);
    rs(5'h14, 16'h0000);
    end_of_test;
  end
endmodule
bind psi_top psi_asserts psi_asserts_i (.*);
